// file: ctrl_model.sv
// Behavioural memory controller that drives the command pins of the power-state decoder.
`timescale 1ns/100ps
module ctrl_model (
   // Clock
   input  wire logic       core_clk,
   // Command pins
   output logic            chip_select_n,
   output logic            clock_enable,
   output logic [9:0]      rise_bits,
   output logic [9:0]      fall_bits
);
   initial begin
      chip_select_n = 1'b1;
      clock_enable  = 1'b0;
      rise_bits     = 10'h000;
      fall_bits     = 10'h000;
   end
   // One command for one cycle, then deselect with enable held; the clock runs free throughout.
   // Don't-care bits take the inverse of the last value, so a stale level never looks fresh.
   task automatic issue(input logic cs_n, input logic cke, input logic [9:0] r,
                        input logic [9:0] f);
      @(posedge core_clk);
      chip_select_n <= cs_n;
      clock_enable  <= cke;
      rise_bits     <= r;
      fall_bits     <= f;
      @(posedge core_clk);
      chip_select_n <= 1'b1;
      rise_bits     <= ~r;
      fall_bits     <= ~f;
   endtask
endmodule

// file: dram_power_state_decoder.sv
// Command sampler and clock-enable power-state machine of a low-power DDR SDRAM.
//
// Notes on behaviour
// (R1) Decode from chip select, bits 0-3, clock enable.
// (R2) Rising and falling command bits are separate fields.
// (R3) Bank commands act on the carried bank field.
// (R4) Auto-precharge flag closes the addressed bank.
// (R5) Controller drives don't-care inputs to valid levels.
// (R6) Self-refresh and deep-sleep exits need no command.
// (R7) Per-bank refresh accepted only with eight banks.
// (R8) Column bit zero is always zero.
// (R9) Clock enable low twice holds low-power state.
// (R10) Falling enable, select high: matching power-down.
// (R11) From idle only: enter self refresh or deep sleep.
// (R12) Rising enable leaves power-down; exit delay follows.
// (R13) Controller toggles clock twice before exit delay.
// (R14) Resetting power-down exits to idle once init done.
// (R15) Deep-sleep exit goes to power-on state.
// (R16) Self-refresh exit returns to idle after delay; idle is entered at once, with exit_wait held through the delay.
// (R17) Enable high twice: normal command decoding.
// (R18) Controller never issues undefined sequences.
// (R19) Idle command: select high, or bits 0-2 high.
// (R20) Controller tracks open rows for power-down choice.
`timescale 1ns/100ps
`include "pwr_state_map.svh"

module dram_power_state_decoder
   import pwr_state_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Command pins
   input  wire logic        chip_select_n,
   input  wire logic        clock_enable,
   input  wire logic [9:0]  rising_edge_command_bit,
   input  wire logic [9:0]  falling_edge_command_bit,
   // Decoded state and command
   output pwr_state_e       power_state,
   output logic [7:0]       banks_open,
   output logic             exit_wait,
   output logic             cmd_valid,
   output cmd_e             cmd_code,
   output logic [2:0]       cmd_bank,
   output logic [11:0]      cmd_column,
   output logic             cmd_auto_precharge
);

   dec_s r;
   dec_s n;

   logic       cs_n;
   logic       cke;
   logic [9:0] rise;
   logic [9:0] fall;
   logic [2:0] bank;
   logic       low_power;
   cmd_e       dec;

   assign cs_n = r.cs_s2;
   assign cke  = r.cke_s2;
   assign rise = r.rise_s2;
   assign fall = r.fall_s2;
   assign bank = rise[`BANK_FIELD_LSB +: 3]; // [R3]
   assign low_power = r.st inside {ST_ACT_HOLD, ST_IDLE_HOLD, ST_RST_HOLD, ST_SELF_REFR,
                                   ST_DEEP_SLEEP};

   // Opcode sits in rising bits 0-3 only; the rest are operands. [R1]
   always_comb begin
      casez (rise[3:0])
         4'b0000: dec = CMD_MRW;
         4'b1000: dec = CMD_MRR;
         4'b0100: dec = (`BANK_COUNT == 8) ? CMD_REF_PB : CMD_NONE; // [R7]
         4'b1100: dec = CMD_REF_AB;
         4'b??10: dec = CMD_ACT;
         4'b?001: dec = CMD_WR;
         4'b?101: dec = CMD_RD;
         4'b1011: dec = CMD_PRE;
         4'b0011: dec = CMD_BST;
         4'b?111: dec = CMD_IDLE; // [R19]
         default: dec = CMD_NONE;
      endcase
   end

   always_comb begin
      n = r;
      // Pins come from the controller's clock; two stages before any use. [R2]
      n.cs_s1   = chip_select_n;
      n.cs_s2   = r.cs_s1;
      n.cke_s1  = clock_enable;
      n.cke_s2  = r.cke_s1;
      n.rise_s1 = rising_edge_command_bit;
      n.rise_s2 = r.rise_s1;
      n.fall_s1 = falling_edge_command_bit;
      n.fall_s2 = r.fall_s1;
      n.cke_prev  = cke;
      n.cmd_valid = 1'b0;
      if (r.init_cnt != `COUNT_RESET) begin
         n.init_cnt = r.init_cnt - 8'h01;
      end
      if (r.exit_cnt != `COUNT_RESET) begin
         n.exit_cnt = r.exit_cnt - 8'h01;
      end
      n.exit_wait = (n.exit_cnt != `COUNT_RESET);
      if (r.st == ST_RESETTING && r.init_cnt == `COUNT_RESET) begin
         n.st = ST_IDLE;
      end
      // Deep states leave on the enable level alone, without a select check. [R6]
      if ((r.st == ST_SELF_REFR || r.st == ST_DEEP_SLEEP) && cke) begin
         n.st = (r.st == ST_SELF_REFR) ? ST_IDLE : ST_POWER_ON; // [R15] [R16]
         if (r.st == ST_SELF_REFR) begin
            n.exit_cnt  = 8'(`SR_EXIT_DELAY_CYC);
            n.exit_wait = 1'b1;
         end
      end else if (!r.cke_prev && !cke) begin
         n.st = r.st; // [R9]
      end else if (!r.cke_prev && cke && cs_n && low_power) begin
         n.exit_cnt  = 8'(`HOLD_EXIT_DELAY_CYC); // [R12]
         n.exit_wait = 1'b1;
         unique case (r.st)
            ST_ACT_HOLD:  n.st = ST_ACTIVE;
            ST_IDLE_HOLD: n.st = ST_IDLE;
            ST_RST_HOLD:  n.st = (r.init_cnt == `COUNT_RESET) ? ST_IDLE : ST_RESETTING; // [R14]
            default:    n.st = r.st;
         endcase
      end else if (r.cke_prev && !cke) begin
         if (cs_n) begin // [R10]
            if (r.st == ST_ACTIVE) begin
               n.st = ST_ACT_HOLD;
            end else if (r.st == ST_IDLE) begin
               n.st = ST_IDLE_HOLD;
            end else if (r.st == ST_RESETTING) begin
               n.st = ST_RST_HOLD;
            end
         end else if (r.st == ST_IDLE) begin // [R11]
            if (rise[2:0] == 3'b100) begin
               n.st = ST_SELF_REFR;
            end else if (rise[2:0] == 3'b011) begin
               n.st = ST_DEEP_SLEEP;
            end
         end
      end else if (r.cke_prev && cke && !cs_n && !low_power) begin // [R17]
         n.cmd_valid  = (dec != CMD_NONE);
         n.cmd        = dec;
         n.cmd_bank   = bank;
         n.cmd_auto_pre = fall[`AUTO_PRE_FALL_BIT];
         // The lowest column bit never travels on the bus. [R8]
         n.cmd_column = {fall[`COL_FALL_LSB +: 9], rise[`COL_RISE_LSB +: 2], 1'b0};
         if (dec == CMD_MRW && {fall[1:0], rise[9:4]} == `RESET_MR_ADDR
             && (r.st == ST_POWER_ON || r.st == ST_IDLE)) begin
            n.st         = ST_RESETTING;
            n.open_banks = `BANKS_RESET;
            n.init_cnt   = 8'(`FINAL_INIT_WAIT_CYC);
         end else if (r.st == ST_IDLE || r.st == ST_ACTIVE) begin
            unique case (dec)
               CMD_ACT: n.open_banks[bank] = 1'b1; // [R3]
               CMD_PRE: begin
                  if (rise[`ALL_BANKS_BIT]) begin
                     n.open_banks = `BANKS_RESET;
                  end else begin
                     n.open_banks[bank] = 1'b0;
                  end
               end
               // Closing at the command is the bank view; the burst itself ends later.
               CMD_RD, CMD_WR: begin
                  if (fall[`AUTO_PRE_FALL_BIT]) begin
                     n.open_banks[bank] = 1'b0; // [R4]
                  end
               end
               default: n.open_banks = r.open_banks;
            endcase
            n.st = (n.open_banks != `BANKS_RESET) ? ST_ACTIVE : ST_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: ST_POWER_ON, cmd: CMD_NONE, cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign power_state        = r.st;
   assign banks_open         = r.open_banks;
   assign exit_wait          = r.exit_wait;
   assign cmd_valid          = r.cmd_valid;
   assign cmd_code           = r.cmd;
   assign cmd_bank           = r.cmd_bank;
   assign cmd_column         = r.cmd_column;
   assign cmd_auto_precharge = r.cmd_auto_pre;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence falling_enable_select_high;
      r.cke_prev && !cke && cs_n;
   endsequence

   sequence rising_enable_select_high;
      !r.cke_prev && cke && cs_n;
   endsequence

   chk_hold_low_power: assert property ( // [R9]
      (!r.cke_prev && !cke && low_power && r.st != ST_SELF_REFR && r.st != ST_DEEP_SLEEP)
      |=> (r.st == $past(r.st)) && !r.cmd_valid)
      else $error("Low-power state left while enable stayed low.");

   chk_column_lsb_zero: assert property ( // [R8]
      r.cmd_valid |-> (r.cmd_column[0] == 1'b0))
      else $error("Column bit zero not forced low.");

   chk_active_hold_entry: assert property ( // [R10]
      (falling_enable_select_high and (r.st == ST_ACTIVE)) |=> (r.st == ST_ACT_HOLD))
      else $error("Active power-down not entered.");

   chk_self_refr_entry: assert property ( // [R11]
      (r.cke_prev && !cke && !cs_n && r.st == ST_IDLE && rise[2:0] == 3'b100)
      |=> (r.st == ST_SELF_REFR))
      else $error("Self refresh not entered from idle.");

   chk_idle_hold_exit: assert property ( // [R12]
      (rising_enable_select_high and (r.st == ST_IDLE_HOLD))
      |=> (r.st == ST_IDLE) && r.exit_wait)
      else $error("Idle power-down exit wrong.");

   chk_deep_exit: assert property ( // [R6] [R15]
      (r.st == ST_DEEP_SLEEP && cke) |=> (r.st == ST_POWER_ON))
      else $error("Deep-sleep exit did not reach power-on.");

   // The exit delay counter loads six cycles, so the wait flag stands for six edges.
   chk_self_refr_exit: assert property ( // [R16]
      (r.st == ST_SELF_REFR && cke) |=> ((r.st == ST_IDLE) && r.exit_wait) [*6] ##1 !r.exit_wait)
      else $error("Self-refresh exit or its delay wrong.");

   chk_rst_hold_exit: assert property ( // [R14]
      (rising_enable_select_high and (r.st == ST_RST_HOLD))
      |=> (r.st == (($past(r.init_cnt) == `COUNT_RESET) ? ST_IDLE : ST_RESETTING)))
      else $error("Resetting power-down exit wrong.");

   chk_auto_precharge: assert property ( // [R4]
      (r.cmd_valid && r.cmd_auto_pre && (r.cmd == CMD_RD || r.cmd == CMD_WR)
       && $past(r.st) inside {ST_IDLE, ST_ACTIVE})
      |-> !r.open_banks[r.cmd_bank])
      else $error("Auto-precharge left bank open.");

   chk_cmd_decode: assert property ( // [R1] [R17]
      (r.cke_prev && cke && !cs_n && !low_power && rise[3:0] == 4'b1011)
      |=> r.cmd_valid && (r.cmd == CMD_PRE) && (r.cmd_bank == $past(bank)))
      else $error("Precharge command not decoded.");

endmodule

// file: dram_power_state_decoder_tb_top.sv
// Self-checking testbench of the power-state decoder.
`timescale 1ns/100ps
module dram_power_state_decoder_tb_top
   import pwr_state_pkg::*;
;
   logic        core_clk;
   logic        rst_n;
   logic        cs_n;
   logic        cke;
   logic [9:0]  rb;
   logic [9:0]  fb;
   pwr_state_e  power_state;
   logic [7:0]  banks_open;
   logic        exit_wait;
   logic        cmd_valid;
   cmd_e        cmd_code;
   logic [2:0]  cmd_bank;
   logic [11:0] cmd_column;
   logic        cmd_auto_pre;
   logic [19:0] notes[$];
   int          num_errors = 0;
   int          tests_run = 0;
   logic [31:0] seed = 32'hceacba12;
   logic [3:0]  misc[6] = '{4'h8, 4'h4, 4'hc, 4'h3, 4'h0, 4'h7};
   cmd_e        misc_code[6] = '{CMD_MRR, CMD_REF_PB, CMD_REF_AB, CMD_BST, CMD_MRW, CMD_IDLE};
   logic [2:0]  b;

   ctrl_model m (.core_clk(core_clk), .chip_select_n(cs_n), .clock_enable(cke),
                 .rise_bits(rb), .fall_bits(fb));
   dram_power_state_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .chip_select_n(cs_n),
      .clock_enable(cke), .rising_edge_command_bit(rb), .falling_edge_command_bit(fb),
      .power_state(power_state), .banks_open(banks_open), .exit_wait(exit_wait),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
      .cmd_column(cmd_column), .cmd_auto_precharge(cmd_auto_pre));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The column always carries a zero in bit zero, whatever the pins say.
   task automatic note(input cmd_e c, input logic [9:0] r, input logic [9:0] f);
      notes.push_back({c, r[9:7], f[9:1], r[6:5], 1'b0, f[0]});
   endtask

   task automatic chk_cmd(input logic [19:0] exp);
      cmp({12'h000, cmd_code, cmd_bank, cmd_column, cmd_auto_pre}, {12'h000, exp});
   endtask

   // Waits a bounded number of cycles for the state, then compares state and open banks.
   task automatic chk_state(input pwr_state_e s, input logic [7:0] bk, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(negedge core_clk);
         if ({power_state, banks_open} === {s, bk})
            break;
      end
      cmp({15'h0000, power_state, banks_open}, {15'h0000, s, bk});
   endtask

   always @(negedge core_clk) begin
      if (cmd_valid === 1'b1) begin
         if (notes.size() == 0)
            cmp({31'h0, cmd_valid}, 32'h0);
         else
            chk_cmd(notes.pop_front());
      end
   end

   task automatic results();
      cmp(notes.size(), 32'h0);
      $display("Comparisons %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      m.issue(1'b1, 1'b1, 10'h000, 10'h000);
      m.issue(1'b0, 1'b1, 10'h3f0, 10'h000);
      note(CMD_MRW, 10'h3f0, 10'h000);
      chk_state(ST_RESETTING, 8'h00, 8);
      m.issue(1'b1, 1'b0, 10'h000, 10'h000);
      chk_state(ST_RST_HOLD, 8'h00, 8);
      m.issue(1'b1, 1'b1, 10'h000, 10'h000);
      chk_state(ST_RESETTING, 8'h00, 8);
      chk_state(ST_IDLE, 8'h00, 60);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         b = seed[2:0];
         // Expected open banks are checked after the first activate, the auto-precharge write and the precharge.
         m.issue(1'b0, 1'b1, {b, seed[9:5], 2'b10}, seed[19:10]);
         note(CMD_ACT, {b, seed[9:5], 2'b10}, seed[19:10]);
         chk_state(ST_ACTIVE, 8'h01 << b, 8);
         m.issue(1'b1, 1'b0, 10'h000, 10'h000);
         chk_state(ST_ACT_HOLD, 8'h01 << b, 8);
         m.issue(1'b0, 1'b0, {b, 7'h05}, 10'h000);
         // Look only once the ignored command has had time to act.
         repeat (3) @(posedge core_clk);
         chk_state(ST_ACT_HOLD, 8'h01 << b, 6);
         m.issue(1'b1, 1'b1, 10'h000, 10'h000);
         chk_state(ST_ACTIVE, 8'h01 << b, 8);
         cmp({31'h0, exit_wait}, 32'h1);
         @(negedge core_clk);
         cmp({31'h0, exit_wait}, 32'h0);
         m.issue(1'b0, 1'b1, {b, seed[26:25], 5'h05}, {seed[31:23], 1'b0});
         note(CMD_RD, {b, seed[26:25], 5'h05}, {seed[31:23], 1'b0});
         m.issue(1'b0, 1'b1, {b, seed[22:21], 5'h01}, {seed[30:22], 1'b1});
         note(CMD_WR, {b, seed[22:21], 5'h01}, {seed[30:22], 1'b1});
         chk_state(ST_IDLE, 8'h00, 8);
         m.issue(1'b0, 1'b1, {b, 7'h02}, 10'h000);
         note(CMD_ACT, {b, 7'h02}, 10'h000);
         // Even passes close one bank, odd passes close all of them.
         m.issue(1'b0, 1'b1, {b, 2'b00, k[0], 4'hb}, 10'h000);
         note(CMD_PRE, {b, 2'b00, k[0], 4'hb}, 10'h000);
         chk_state(ST_IDLE, 8'h00, 8);
      end
      for (int k = 0; k < 6; k++) begin
         m.issue(1'b0, 1'b1, {6'h15, misc[k]}, 10'h2aa);
         note(misc_code[k], {6'h15, misc[k]}, 10'h2aa);
         repeat (8) @(posedge core_clk);
      end
      m.issue(1'b1, 1'b0, 10'h000, 10'h000);
      chk_state(ST_IDLE_HOLD, 8'h00, 8);
      m.issue(1'b1, 1'b1, 10'h000, 10'h000);
      chk_state(ST_IDLE, 8'h00, 8);
      m.issue(1'b0, 1'b0, 10'h004, 10'h000);
      chk_state(ST_SELF_REFR, 8'h00, 8);
      m.issue(1'b1, 1'b1, 10'h000, 10'h000);
      chk_state(ST_IDLE, 8'h00, 8);
      cmp({31'h0, exit_wait}, 32'h1);
      repeat (6) @(negedge core_clk);
      cmp({31'h0, exit_wait}, 32'h0);
      repeat (10) @(posedge core_clk);
      m.issue(1'b0, 1'b0, 10'h003, 10'h000);
      chk_state(ST_DEEP_SLEEP, 8'h00, 8);
      m.issue(1'b1, 1'b1, 10'h000, 10'h000);
      chk_state(ST_POWER_ON, 8'h00, 8);
      repeat (6) @(posedge core_clk);
      results();
   end
endmodule

// file: pwr_state_map.svh
// Timing counts, field positions and reset values of the power-state decoder.
`ifndef PWR_STATE_MAP_SVH
`define PWR_STATE_MAP_SVH
`define CLK_PERIOD_NS        25
`define FINAL_INIT_WAIT_NS   1000
`define HOLD_EXIT_DELAY_NS   8
`define SR_EXIT_DELAY_NS     140
`define FINAL_INIT_WAIT_CYC  ((`FINAL_INIT_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_EXIT_DELAY_CYC  ((`HOLD_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR_EXIT_DELAY_CYC    ((`SR_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BANK_COUNT           8
`define BANK_FIELD_LSB       7
`define COL_RISE_LSB         5
`define COL_FALL_LSB         1
`define AUTO_PRE_FALL_BIT    0
`define ALL_BANKS_BIT        4
`define RESET_MR_ADDR        8'h3f
`define BANKS_RESET          8'h00
`define COUNT_RESET          8'h00
`endif

// file: pwr_state_pkg.sv
// Types of the power-state decoder: states, decoded commands and the state record.
package pwr_state_pkg;

   typedef enum logic [8:0] {
      ST_POWER_ON   = 9'h001,
      ST_RESETTING  = 9'h002,
      ST_IDLE       = 9'h004,
      ST_ACTIVE     = 9'h008,
      ST_ACT_HOLD   = 9'h010,
      ST_IDLE_HOLD  = 9'h020,
      ST_RST_HOLD   = 9'h040,
      ST_SELF_REFR  = 9'h080,
      ST_DEEP_SLEEP = 9'h100
   } pwr_state_e;

   typedef enum logic [3:0] {
      CMD_NONE   = 4'h0,
      CMD_MRW    = 4'h1,
      CMD_MRR    = 4'h2,
      CMD_REF_PB = 4'h3,
      CMD_REF_AB = 4'h4,
      CMD_ACT    = 4'h5,
      CMD_WR     = 4'h6,
      CMD_RD     = 4'h7,
      CMD_PRE    = 4'h8,
      CMD_BST    = 4'h9,
      CMD_IDLE   = 4'ha
   } cmd_e;

   typedef struct packed {
      logic       cs_s1;
      logic       cs_s2;
      logic       cke_s1;
      logic       cke_s2;
      logic [9:0] rise_s1;
      logic [9:0] rise_s2;
      logic [9:0] fall_s1;
      logic [9:0] fall_s2;
      logic       cke_prev;
      pwr_state_e st;
      logic [7:0] open_banks;
      logic [7:0] init_cnt;
      logic [7:0] exit_cnt;
      logic       exit_wait;
      logic       cmd_valid;
      cmd_e       cmd;
      logic [2:0] cmd_bank;
      logic [11:0] cmd_column;
      logic       cmd_auto_pre;
   } dec_s;

endpackage
